// [bench/hppb_host.sv]
/*
 * Host model: drives select, strobes, latch strobe, address and data pins.
 * Assumes the bench resolves the data lines from the port's output enable.
 */
`timescale 1ns/1ps
module hppb_host (
	// Clock
	input wire logic clock_in,
	// Host pins
	output logic cs_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic ale_out,
	output logic [3:0] addr_out,
	output logic [7:0] data_out
);
	// Idle bus, latch strobe tied high for plain use until the first multiplexed access
	initial begin
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		ale_out = 1'b1;
		addr_out = 4'h0;
		data_out = 8'h00;
	end

	// One access; entered just after a rising edge
	task automatic access(input logic mux, input logic wr, input logic sel,
		input logic [3:0] a, input logic [7:0] d);
		if (mux) begin
			// A tied-high latch strobe must drop first, so that its rise is an edge
			if (ale_out) begin
				ale_out = 1'b0;
				repeat (4) @(posedge clock_in);
				#1;
			end
			addr_out = 4'h0;
			data_out = {4'h0, a};
			ale_out = 1'b1;
			repeat (4) @(posedge clock_in);
			#1 ale_out = 1'b0;
			repeat (4) @(posedge clock_in);
			#1;
		end else begin
			addr_out = a;
		end
		// Released lines show the inverse of the last level
		data_out = wr ? d : ~data_out;
		cs_n_out = ~sel;
		rd_n_out = mux ? wr : ~wr;
		wr_n_out = mux & ~wr;
		repeat (6) @(posedge clock_in);
		#1 rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		repeat (4) @(posedge clock_in);
		#1 cs_n_out = 1'b1;
		repeat (5) @(posedge clock_in);
		#1;
	endtask : access
endmodule : hppb_host

// [bench/hppb_port_tb.sv]
/*
 * Self-checking bench of the host bus port with a small register file.
 * Assumes the port and host model are compiled first.
 */
`timescale 1ns/1ps
module hppb_port_tb;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cs_n, rd_n, wr_n, ale, oe_n, aux_irq, irq_pend, int_n, reg_rd, reg_wr, mux;
	logic [3:0] addr, reg_addr;
	logic [7:0] hdata, dout, rdata, wdata, bus_lvl;
	logic [13:0] notes [$];
	logic [31:0] rng = 32'hEE8F;
	logic rd_seen = 1'b0;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;

	always #4 clock_in = ~clock_in;
	// Register file answer and data line level
	assign rdata = {~reg_addr, reg_addr};
	assign bus_lvl = oe_n ? hdata : dout;

	hppb_host i_host (.clock_in(clock_in), .cs_n_out(cs_n), .rd_n_out(rd_n),
		.wr_n_out(wr_n), .ale_out(ale), .addr_out(addr), .data_out(hdata));
	hppb_port i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .cs_n_in(cs_n),
		.rd_n_in(rd_n), .wr_n_in(wr_n), .ale_in(ale), .reg_addr_in(addr),
		.host_data_bus_in(bus_lvl), .host_data_bus_out(dout),
		.host_data_bus_oe_n_out(oe_n), .aux_irq_in(aux_irq),
		.irq_pending_in(irq_pend), .int_n_out(int_n), .reg_rd_data_in(rdata),
		.reg_addr_out(reg_addr), .reg_rd_out(reg_rd), .reg_wr_out(reg_wr),
		.reg_wr_data_out(wdata), .mux_mode_out(mux));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// Matches each finished cycle to the oldest note; cuts a hang short
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		rd_seen <= reg_rd;
		if (reg_wr === 1'b1 || rd_seen === 1'b1) begin
			if (notes.size() == 0) chk("unexpected cycle", 14'h0, 14'h3FFF);
			else chk("bus cycle", {mux, reg_wr | oe_n, reg_addr, reg_wr ? wdata : dout},
				notes.pop_front());
		end
		if (cycles == 2000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// Every mode and direction, then unselected cycles, then interrupts
	initial begin
		aux_irq = 1'b0;
		irq_pend = 1'b0;
		repeat (6) @(posedge clock_in);
		#1 rstn_in = 1'b1;
		repeat (4) @(posedge clock_in);
		#1;
		for (int i = 0; i < 16; i++) begin
			logic sel;
			sel = !(i >= 12 && i < 15);
			rng = xs(rng);
			if (sel) notes.push_back({i[1], i[0], rng[3:0],
				i[0] ? rng[15:8] : {~rng[3:0], rng[3:0]}});
			i_host.access(i[1], i[0], sel, rng[3:0], rng[15:8]);
			chk("mode after cycle", {13'h0, mux}, {13'h0, i[1] & ~sel});
		end
		// Unselected latch strobe leaves multiplexed mode on, then a reset clears it
		i_host.access(1'b1, 1'b0, 1'b0, 4'h0, 8'h00);
		chk("mode before reset", {13'h0, mux}, 14'h0001);
		rstn_in = 1'b0;
		repeat (2) @(posedge clock_in);
		#1 rstn_in = 1'b1;
		chk("mode in reset", {13'h0, mux}, 14'h0000);
		repeat (4) @(posedge clock_in);
		#1 chk("mode after reset", {13'h0, mux}, 14'h0000);
		for (int k = 0; k < 4; k++) begin
			{aux_irq, irq_pend} = k[1:0];
			repeat (5) @(posedge clock_in);
			#1 chk("interrupt pin", {13'h0, int_n}, {13'h0, k == 0});
		end
		// Every noted cycle must have appeared
		chk("notes left", 14'(notes.size()), 14'h0000);
		tally_and_finish();
	end
endmodule : hppb_port_tb

// [core/hppb_pkg.sv]
/*
 * Shared constants of the host parallel bus port: bus widths and reset values.
 * Assumes nothing of its surroundings; it is compiled before every other file.
 */
package hppb_pkg;
	// Width of the host data lines
	localparam int DATA_W = 8;
	// Width of a register address
	localparam int ADDR_W = 4;
	// Field of the data lines that carries the address in multiplexed mode
	localparam int ADDR_LSB = 0;
	// Flip-flop stages in each input synchroniser
	localparam int SYNC_STAGES = 2;
	// Value after reset of the data output register
	localparam logic [7:0] DATA_RST = 8'h00;
	// Value after reset of the address registers
	localparam logic [3:0] ADDR_RST = 4'h0;
	// Value after reset of a synchronised active-low strobe or select
	localparam logic STROBE_RST = 1'b1;
endpackage : hppb_pkg

// [core/hppb_port.sv]
/*
 * Byte-wide host bus port: detects multiplexed or plain bus use from the latch
 * strobe, decodes read and write cycles and drives the interrupt pin.
 * Assumes a register file on clock_in that answers reg_addr_out combinationally
 * on reg_rd_data_in, and an external buffer that resolves the data pins.
 */
// Contract
// R1: Plain addressing by default, without latch strobe edges
// R2: Latch strobe rising edge enters multiplexed mode
// R3: Reset or select release leaves multiplexed mode
// R4: Static latch strobe keeps plain mode
// R5: New address per latch strobe, select ignored
// R6: Address from pins plain, latched when multiplexed
// R7: Data lines carry data, or address and data
// R8: Multiplexed: low read strobe means register read
// R9: Multiplexed: low write strobe means register write
// R10: Plain: read strobe level selects direction
// R11: Plain: low write strobe enables the cycle
// R12: Only answer while selected, else release lines
// R13: Interrupt pin low while anything is pending
// R14: Host ties address pins in multiplexed use
// R15: Host ties latch strobe high for plain use; the host model holds it low after its first multiplexed access
// R16: Address taken from low data on strobe fall
// R17: Plain cycle needs write strobe and select low
// R18: Synchronise pins before edge detection and use
`timescale 1ns/1ps
module hppb_port (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// Host bus pins
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic ale_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] host_data_bus_in,
	output logic [7:0] host_data_bus_out,
	output logic host_data_bus_oe_n_out,
	// Interrupt sources and pin
	input wire logic aux_irq_in,
	input wire logic irq_pending_in,
	output logic int_n_out,
	// Register file side
	input wire logic [7:0] reg_rd_data_in,
	output logic [3:0] reg_addr_out,
	output logic reg_rd_out,
	output logic reg_wr_out,
	output logic [7:0] reg_wr_data_out,
	output logic mux_mode_out
);
	// Synchronised pins
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic ale_s;
	logic aux_s;
	logic [3:0] addr_s;
	logic [7:0] data_s;
	// Edge detector history
	logic ale_d_r;
	logic cs_n_d_r;
	// Mode and latched address
	logic mux_r;
	logic mux_nxt;
	logic [3:0] lat_addr_r;
	// Cycle tracking
	logic rd_act_d_r;
	logic wr_act_d_r;
	logic [7:0] wdata_r;

	// Strobes, select and auxiliary interrupt, all reset high
	hppb_sync #(.W(5), .RST({5{hppb_pkg::STROBE_RST}})) u_sync_ctl ( // R18
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.d_in({cs_n_in, rd_n_in, wr_n_in, ale_in, aux_irq_in}),
		.q_out({cs_n_s, rd_n_s, wr_n_s, ale_s, aux_s})
	);

	// Address pins and data lines
	hppb_sync #(.W(12), .RST(12'h000)) u_sync_dat ( // R18
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.d_in({reg_addr_in, host_data_bus_in}),
		.q_out({addr_s, data_s})
	);

	// Edges of the latch strobe and select
	wire ale_rise = ale_s && !ale_d_r; // R2
	wire ale_fall = !ale_s && ale_d_r; // R16
	wire cs_release = cs_n_s && !cs_n_d_r; // R3
	wire selected = !cs_n_s; // R12

	// Mode: a rising latch strobe sets, select release clears, set wins
	always_comb begin
		mux_nxt = mux_r; // R1 R4
		if (ale_rise) begin
			mux_nxt = 1'b1; // R2
		end else if (cs_release) begin
			mux_nxt = 1'b0; // R3
		end
	end

	// Address in use: latched in multiplexed mode, pins otherwise
	wire [3:0] eff_addr = mux_r ? lat_addr_r : addr_s; // R6 R14

	// Cycle decode in both modes
	wire rd_mux = !rd_n_s && wr_n_s; // R8
	wire wr_mux = !wr_n_s && rd_n_s; // R9
	wire rd_plain = !wr_n_s && rd_n_s; // R10 R11 R17
	wire wr_plain = !wr_n_s && !rd_n_s; // R10 R11 R17
	wire rd_act = selected && (mux_r ? rd_mux : rd_plain); // R12
	wire wr_act = selected && (mux_r ? wr_mux : wr_plain); // R12
	wire wr_end = wr_act_d_r && !wr_act;
	// Hold the address through the last write cycle so the commit sees it
	wire addr_upd = !wr_act_d_r;

	// Edge history, mode and address latch
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ale_d_r <= hppb_pkg::STROBE_RST;
			cs_n_d_r <= hppb_pkg::STROBE_RST;
			mux_r <= 1'b0; // R3
			lat_addr_r <= hppb_pkg::ADDR_RST;
		end else begin
			ale_d_r <= ale_s;
			cs_n_d_r <= cs_n_s;
			mux_r <= mux_nxt;
			// Any falling strobe latches, select level is not looked at
			if ((mux_r || ale_d_r) && ale_fall) begin
				lat_addr_r <= data_s[hppb_pkg::ADDR_LSB +: hppb_pkg::ADDR_W]; // R5 R16 R7
			end
		end
	end

	// Read path: drive the lines only during a selected read
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_act_d_r <= 1'b0;
			host_data_bus_oe_n_out <= 1'b1;
			host_data_bus_out <= hppb_pkg::DATA_RST;
			reg_rd_out <= 1'b0;
		end else begin
			rd_act_d_r <= rd_act;
			host_data_bus_oe_n_out <= !rd_act; // R8 R10 R12
			host_data_bus_out <= reg_rd_data_in; // R7
			reg_rd_out <= rd_act && !rd_act_d_r;
		end
	end

	// Write path: track the data, commit one pulse at the strobe end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_act_d_r <= 1'b0;
			wdata_r <= hppb_pkg::DATA_RST;
			reg_wr_out <= 1'b0;
			reg_wr_data_out <= hppb_pkg::DATA_RST;
		end else begin
			wr_act_d_r <= wr_act;
			if (wr_act) begin
				wdata_r <= data_s; // R9 R10
			end
			reg_wr_out <= wr_end; // R9 R11
			reg_wr_data_out <= wdata_r;
		end
	end

	// Address, mode and interrupt outputs
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_addr_out <= hppb_pkg::ADDR_RST;
			mux_mode_out <= 1'b0;
			int_n_out <= 1'b1;
		end else begin
			if (addr_upd) begin
				reg_addr_out <= eff_addr; // R6
			end
			mux_mode_out <= mux_r;
			int_n_out <= !(irq_pending_in || aux_s); // R13
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	// A latch strobe pulse: rise, then fall
	sequence ale_pulse_s;
		ale_rise ##[1:1000] ale_fall;
	endsequence

	mux_enter_a: assert property (ale_rise |=> mux_r) // R2
		else $error("rising latch strobe did not enter multiplexed mode");
	mux_exit_a: assert property (mux_r && cs_release && !ale_rise |=> !mux_r) // R3
		else $error("select release did not leave multiplexed mode");
	plain_hold_a: assert property (!mux_r && !ale_rise |=> !mux_r) // R1 R4
		else $error("left plain mode without a latch strobe edge");
	addr_latch_a: assert property (ale_pulse_s |=> lat_addr_r == $past(data_s[3:0])) // R5 R16
		else $error("address not latched on falling latch strobe");
	addr_pins_a: assert property (!mux_r && !wr_act_d_r |=> reg_addr_out == $past(addr_s)) // R6
		else $error("plain mode address does not follow the pins");
	release_bus_a: assert property (cs_n_s |=> host_data_bus_oe_n_out) // R12
		else $error("data lines driven while not selected");
	mux_read_a: assert property (mux_r && selected && rd_mux |=> !host_data_bus_oe_n_out) // R8
		else $error("multiplexed read not driving the lines");
	plain_dir_a: assert property (!mux_r && selected && wr_plain |=> host_data_bus_oe_n_out) // R10 R11
		else $error("plain write drove the data lines");
	plain_enable_a: assert property (!mux_r && wr_n_s |=> host_data_bus_oe_n_out) // R11 R17
		else $error("plain cycle answered without the write strobe low");
	write_commit_a: assert property (wr_act ##1 !wr_act |=> reg_wr_out && reg_wr_data_out == $past(wdata_r)) // R9
		else $error("write not committed at strobe end");
	irq_pin_a: assert property (irq_pending_in |=> !int_n_out) // R13
		else $error("interrupt pin not low while pending");
endmodule : hppb_port

// [core/hppb_sync.sv]
/*
 * Multi-bit two-stage synchroniser for asynchronous host pins.
 * Assumes each bit is sampled on its own; bus skew is settled by the strobe timing.
 */
`timescale 1ns/1ps
module hppb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// Asynchronous input and synchronised output
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	// First stage, read only by the second stage
	logic [W-1:0] meta_r;

	// Two flip-flops in series
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_r <= RST;
			q_out <= RST;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule : hppb_sync
